// ==== mac_defs.svh ====
/*
 * constants for the mode based access checker: register offsets, field
 * positions, reset values and the physical memory map.
 * assumes inclusion by bare name from the checker and its package users.
 */
`ifndef MAC_DEFS_SVH
`define MAC_DEFS_SVH

// ==========================================================
// register byte offsets (axi4-lite, one word each)
`define OFS_MODE          12'h000
`define OFS_FW_CTRL_LOW   12'h004
`define OFS_FW_CTRL_HIGH  12'h008
`define OFS_XW_BASE_LOW   12'h00c
`define OFS_XW_BASE_HIGH  12'h010
`define OFS_XW_SIZE_LOW   12'h014
`define OFS_XW_SIZE_HIGH  12'h018
`define OFS_OPTIONS       12'h01c
`define OFS_STATUS        12'h020
`define OFS_DENY_ADDR     12'h024
`define OFS_SEG_BASE      12'h100

// ==========================================================
// field positions
`define OPT_EE_NO_ROM     0
`define OPT_DMA_NO_ROM    1
`define OPT_DMA_NO_EE     2
`define SEG_R             0
`define SEG_W             1
`define SEG_X             2
`define SEG_HW            3

// ==========================================================
// reset values
`define RST_MODE          3'h0
`define RST_WORD          16'h0000

// ==========================================================
// physical memory map (24-bit address, plain defaults)
`define ROM_LO            24'h000000
`define TROM_END          24'h004000
`define ROM_END           24'h040000
`define EE_LO             24'h100000
`define FWEE_END          24'h104000
`define SECROW_LO         24'h1ff000
`define EE_END            24'h200000
`define RAM_LO            24'h200000
`define FWRAM_END         24'h200800
`define RAM_END           24'h202000
`define OPRAM_LO          24'h300000
`define OPRAM_END         24'h301000
`define SFR_LO            24'hff0000
`define SFR_HWC_LO        24'hff8000

`define SEG_COUNT         64
`endif

// ==== mac_pkg.sv ====
/*
 * types for the mode based access checker.
 * assumes mac_defs.svh is available for the constants.
 */
package mac_pkg;
	typedef enum logic [2:0] {
		MODE_BOOT,
		MODE_TEST,
		MODE_FIRMWARE,
		MODE_SYSTEM,
		MODE_USER
	} cpu_mode_t;

	typedef enum logic [1:0] {
		INIT_CPU,
		INIT_DMA,
		INIT_CRYPTO
	} initiator_t;

	// one access request presented to the checker
	typedef struct packed {
		logic        valid;
		initiator_t  who;
		logic        rd;
		logic        wr;
		logic        ex;
		logic        from_ee;
		logic        fw_called_sys;
		cpu_mode_t   dma_mode;
		logic [23:0] vaddr;
	} acc_req_t;

	// answer, registered
	typedef struct packed {
		logic        valid;
		logic        grant;
		logic [23:0] paddr;
	} acc_rsp_t;

	// one segment table entry
	typedef struct packed {
		logic [3:0]  rights;
		logic [23:0] first;
		logic [23:0] last;
		logic [23:0] reloc;
	} seg_entry_t;
endpackage

// ==== seg_table_mem.sv ====
/*
 * segment table storage: 64 entries, one write port, every entry read out in parallel.
 * assumes the checker drives the write index and entry on clk_sys.
 */
`include "mac_defs.svh"
module seg_table_mem
	import mac_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic       we,
	input  wire logic [5:0] widx,
	input  wire seg_entry_t wdata,
	output seg_entry_t      table_ff [`SEG_COUNT]
);
	// all entries visible at once: the checker compares every segment in parallel
	genvar g;
	generate
		for (g = 0; g < `SEG_COUNT; g++) begin : g_ent
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn)
					table_ff[g] <= '0;
				else if (we && widx == 6'(g))
					table_ff[g] <= wdata;
			end
		end
	endgenerate
endmodule

// ==== mode_based_access_checker.sv ====
/*
 * mode based access checker: judges every memory and sfr access by cpu mode,
 * segment table, firewall and exchange window before memory sees it.
 * assumes requesters hold a request one cycle; answers arrive a cycle later.
 */
// Overview of operation
// - every access is judged before it reaches the addressed location
// - each cpu sfr access is granted or denied using current cpu mode
// - user hw-register access also follows the segment table, firmware hw-register access the firewall
// - any denied read or write raises an exception to the cpu
// - boot mode: test rom rx, firmware eeprom rwx, firmware ram rw
// - test mode: all rom rx, all eeprom rwx, all ram rw
// - firmware mode: firmware rom rx, firmware ram rw
// - firmware mode: all eeprom rw; firmware eeprom rwx gated by firewall
// - system mode: application rom rx, eeprom rwx, ram rw
// - user mode: segment rights decide; no rom write, no ram execute
// - firmware mode reaches the exchange window in application ram
// - boot and firmware modes may read security rows
// - firmware called from system gets application eeprom rw
// - crypto coprocessor gets rw to its operand ram
// - optionally deny rom reads by code executing from eeprom
// - optionally deny dma reads of rom and of eeprom separately
// - decisions depend only on the request, mode, segment table and configuration registers
// - segment table holds 64 entries with rights, bounds, offset, hw rights
// - an entry with no rights is disabled and never matches
// - privilege is one of five modes chosen by register
`include "mac_defs.svh"
module mode_based_access_checker
	import mac_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire acc_req_t    req,
	output acc_rsp_t         rsp_ff,
	output logic             exception_ff
);
	// ==========================================================
	// configuration registers
	cpu_mode_t   mode_ff;
	logic [15:0] fw_lo_ff, fw_hi_ff, xb_lo_ff, xb_hi_ff, xs_lo_ff, xs_hi_ff;
	logic [2:0]  opt_ff;
	logic [15:0] deny_cnt_ff;
	logic [23:0] deny_addr_ff;
	logic [5:0]  seg_widx_ff;
	logic [71:0] seg_stage_ff;
	seg_entry_t  seg_tab [`SEG_COUNT];

	// ==========================================================
	// axi4-lite write path: address and data may come in any order
	logic        aw_held_ff, w_held_ff;
	logic [11:0] aw_ff;
	logic [31:0] w_ff;
	wire         aw_take = s_axi_awvalid && s_axi_awready;
	wire         w_take  = s_axi_wvalid && s_axi_wready;
	wire         wr_go   = aw_held_ff && w_held_ff && !s_axi_bvalid;
	wire         seg_wr  = wr_go && aw_ff[11:8] == `OFS_SEG_BASE >> 8;
	wire [3:0]   seg_word = aw_ff[5:2];

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			aw_ff      <= '0;
			w_ff       <= '0;
		end else begin
			if (aw_take) begin
				aw_held_ff <= 1'b1;
				aw_ff      <= s_axi_awaddr;
			end else if (wr_go) aw_held_ff <= 1'b0;
			if (w_take) begin
				w_held_ff <= 1'b1;
				w_ff      <= s_axi_wdata;
			end else if (wr_go) w_held_ff <= 1'b0;
		end
	end
	assign s_axi_awready = !aw_held_ff;
	assign s_axi_wready  = !w_held_ff;

	function automatic logic [15:0] upd16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		upd16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	logic [3:0] wstrb_ff;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) wstrb_ff <= '0;
		else if (w_take) wstrb_ff <= s_axi_wstrb;
	end

	wire known_w = aw_ff == `OFS_MODE || aw_ff == `OFS_FW_CTRL_LOW || aw_ff == `OFS_FW_CTRL_HIGH
		|| aw_ff == `OFS_XW_BASE_LOW || aw_ff == `OFS_XW_BASE_HIGH || aw_ff == `OFS_XW_SIZE_LOW
		|| aw_ff == `OFS_XW_SIZE_HIGH || aw_ff == `OFS_OPTIONS || aw_ff == `OFS_STATUS || seg_wr;

	// mode register: only values of the five modes are accepted
	wire mode_ok = w_ff[2:0] <= 3'(MODE_USER);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mode_ff  <= MODE_BOOT;
			fw_lo_ff <= `RST_WORD;
			fw_hi_ff <= `RST_WORD;
			xb_lo_ff <= `RST_WORD;
			xb_hi_ff <= `RST_WORD;
			xs_lo_ff <= `RST_WORD;
			xs_hi_ff <= `RST_WORD;
			opt_ff   <= '0;
		end else if (wr_go) begin
			if (aw_ff == `OFS_MODE && mode_ok && wstrb_ff[0]) mode_ff <= cpu_mode_t'(w_ff[2:0]);
			if (aw_ff == `OFS_FW_CTRL_LOW)  fw_lo_ff <= upd16(fw_lo_ff, w_ff, wstrb_ff);
			if (aw_ff == `OFS_FW_CTRL_HIGH) fw_hi_ff <= upd16(fw_hi_ff, w_ff, wstrb_ff);
			if (aw_ff == `OFS_XW_BASE_LOW)  xb_lo_ff <= upd16(xb_lo_ff, w_ff, wstrb_ff);
			if (aw_ff == `OFS_XW_BASE_HIGH) xb_hi_ff <= upd16(xb_hi_ff, w_ff, wstrb_ff);
			if (aw_ff == `OFS_XW_SIZE_LOW)  xs_lo_ff <= upd16(xs_lo_ff, w_ff, wstrb_ff);
			if (aw_ff == `OFS_XW_SIZE_HIGH) xs_hi_ff <= upd16(xs_hi_ff, w_ff, wstrb_ff);
			if (aw_ff == `OFS_OPTIONS && wstrb_ff[0]) opt_ff <= w_ff[2:0];
		end
	end

	logic [1:0] bresp_ff;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			bresp_ff     <= 2'h0;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			bresp_ff     <= known_w ? 2'h0 : 2'h2;
		end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
	end
	assign s_axi_bresp = bresp_ff;

	// ==========================================================
	// segment entry staged over three words, index at +0xc, written on the word at +0x10
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			seg_widx_ff  <= '0;
			seg_stage_ff <= '0;
		end else if (seg_wr) begin
			case (seg_word)
				4'h0: seg_stage_ff[71:48] <= w_ff[23:0];
				4'h1: seg_stage_ff[47:24] <= w_ff[23:0];
				4'h2: seg_stage_ff[23:0]  <= w_ff[23:0];
				4'h3: seg_widx_ff         <= w_ff[5:0];
				default: ;
			endcase
		end
	end
	// word 4 commits {rights, first, last, reloc} into the table
	wire        seg_commit = seg_wr && seg_word == 4'h4;
	seg_entry_t seg_wdata;
	assign seg_wdata = {w_ff[3:0], seg_stage_ff};

	seg_table_mem u_seg (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.we      (seg_commit),
		.widx    (seg_widx_ff),
		.wdata   (seg_wdata),
		.table_ff(seg_tab)
	);

	// ==========================================================
	// axi4-lite read path
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	wire         ar_take = s_axi_arvalid && s_axi_arready;
	wire [31:0]  rd_mux =
		s_axi_araddr == `OFS_MODE         ? {29'h0, mode_ff} :
		s_axi_araddr == `OFS_FW_CTRL_LOW  ? {16'h0, fw_lo_ff} :
		s_axi_araddr == `OFS_FW_CTRL_HIGH ? {16'h0, fw_hi_ff} :
		s_axi_araddr == `OFS_XW_BASE_LOW  ? {16'h0, xb_lo_ff} :
		s_axi_araddr == `OFS_XW_BASE_HIGH ? {16'h0, xb_hi_ff} :
		s_axi_araddr == `OFS_XW_SIZE_LOW  ? {16'h0, xs_lo_ff} :
		s_axi_araddr == `OFS_XW_SIZE_HIGH ? {16'h0, xs_hi_ff} :
		s_axi_araddr == `OFS_OPTIONS      ? {29'h0, opt_ff} :
		s_axi_araddr == `OFS_STATUS       ? {16'h0, deny_cnt_ff} :
		s_axi_araddr == `OFS_DENY_ADDR    ? {8'h0, deny_addr_ff} : 32'h0;
	wire rd_known = s_axi_araddr <= `OFS_DENY_ADDR && s_axi_araddr[1:0] == 2'h0;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			rdata_ff     <= '0;
			rresp_ff     <= 2'h0;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			rdata_ff     <= rd_known ? rd_mux : 32'h0;
			rresp_ff     <= rd_known ? 2'h0 : 2'h2;
		end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
	end
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	// ==========================================================
	// access decision, all combinational from request and configuration
	wire [23:0] va      = req.vaddr;
	wire [31:0] fw_mask = {fw_hi_ff, fw_lo_ff};
	wire [23:0] xw_base = {xb_hi_ff[7:0], xb_lo_ff};
	wire [23:0] xw_size = {xs_hi_ff[7:0], xs_lo_ff};
	// dma keeps the mode it was started in
	wire cpu_mode_t eff_mode = req.who == INIT_DMA ? req.dma_mode : mode_ff;

	// segment match: disabled entries (no rights) never match
	logic [`SEG_COUNT-1:0] hit;
	genvar s;
	generate
		for (s = 0; s < `SEG_COUNT; s++) begin : g_hit
			assign hit[s] = |seg_tab[s].rights[2:0] && va >= seg_tab[s].first && va <= seg_tab[s].last;
		end
	endgenerate
	// lowest matching entry wins
	logic [5:0] hit_idx;
	always_comb begin
		hit_idx = '0;
		for (int i = `SEG_COUNT - 1; i >= 0; i--)
			if (hit[i]) hit_idx = 6'(i);
	end
	wire        seg_hit = |hit;
	seg_entry_t seg_sel;
	assign seg_sel = seg_tab[hit_idx];
	// user addresses are virtual; others map flat
	wire [23:0] pa = eff_mode == MODE_USER ? 24'(va + seg_sel.reloc) : va;

	function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
		in_rng = a >= lo && a < hi;
	endfunction

	wire in_trom  = in_rng(pa, `ROM_LO, `TROM_END);
	wire in_rom   = in_rng(pa, `ROM_LO, `ROM_END);
	wire in_arom  = in_rom && !in_trom;
	wire in_ee    = in_rng(pa, `EE_LO, `EE_END);
	wire in_fwee  = in_rng(pa, `EE_LO, `FWEE_END);
	wire in_aee   = in_ee && !in_fwee;
	wire in_sec   = in_rng(pa, `SECROW_LO, `EE_END);
	wire in_ram   = in_rng(pa, `RAM_LO, `RAM_END);
	wire in_fwram = in_rng(pa, `RAM_LO, `FWRAM_END);
	wire in_aram  = in_ram && !in_fwram;
	wire in_xw    = in_aram && pa >= xw_base && {1'b0, pa} < {1'b0, xw_base} + {1'b0, xw_size};
	wire in_opram = in_rng(pa, `OPRAM_LO, `OPRAM_END);
	wire in_sfr   = pa >= `SFR_LO;
	wire in_hwc   = pa >= `SFR_HWC_LO;
	wire rx = !req.wr;
	wire rw = !req.ex;
	// firewall: one enable bit per 1 KiB block of hardware sfrs
	wire fw_ok = fw_mask[pa[14:10]];
	wire seg_ok = seg_hit && (!req.rd || seg_sel.rights[`SEG_R]) && (!req.wr || seg_sel.rights[`SEG_W])
		&& (!req.ex || seg_sel.rights[`SEG_X]);

	logic grant_c;
	always_comb begin
		grant_c = 1'b0;
		if (req.who == INIT_CRYPTO)
			grant_c = in_opram && rw;
		else if (in_sfr) begin
			// sfr rights follow the mode alone, hardware group also firewall/segment
			case (eff_mode)
				MODE_BOOT, MODE_TEST, MODE_SYSTEM: grant_c = !req.ex;
				MODE_FIRMWARE: grant_c = !req.ex && (!in_hwc || fw_ok);
				MODE_USER:     grant_c = !req.ex && in_hwc && seg_hit && seg_sel.rights[`SEG_HW];
				default:       grant_c = 1'b0;
			endcase
		end else begin
			case (eff_mode)
				MODE_BOOT: grant_c = (in_trom && rx) || (in_fwee) || (in_fwram && rw)
					|| (in_sec && req.rd && !req.wr && !req.ex);
				MODE_TEST: grant_c = (in_rom && rx) || in_ee || (in_ram && rw);
				MODE_FIRMWARE: grant_c = (in_trom && rx) || (in_fwram && rw)
					|| (in_ee && rw) || (in_fwee && fw_mask[31])
					|| (in_xw && rw)
					|| (in_sec && req.rd && !req.wr && !req.ex)
					|| (in_aee && rw && req.fw_called_sys);
				MODE_SYSTEM: grant_c = (in_arom && rx) || in_aee || (in_aram && rw);
				MODE_USER: grant_c = seg_ok && ((in_arom && !req.wr) || in_aee || (in_aram && !req.ex));
				default: grant_c = 1'b0;
			endcase
		end
		if (in_rom && req.rd && req.from_ee && opt_ff[`OPT_EE_NO_ROM]) grant_c = 1'b0;
		if (req.who == INIT_DMA && req.rd && ((in_rom && opt_ff[`OPT_DMA_NO_ROM])
			|| (in_ee && opt_ff[`OPT_DMA_NO_EE]))) grant_c = 1'b0;
	end

	// ==========================================================
	// answer: memory only sees paddr with grant; deny raises exception
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rsp_ff       <= '0;
			exception_ff <= 1'b0;
			deny_cnt_ff  <= '0;
			deny_addr_ff <= '0;
		end else begin
			rsp_ff.valid <= req.valid;
			rsp_ff.grant <= req.valid && grant_c;
			rsp_ff.paddr <= req.valid && grant_c ? pa : 24'h0;
			exception_ff <= req.valid && !grant_c;
			if (req.valid && !grant_c) begin
				deny_cnt_ff  <= 16'(deny_cnt_ff + 16'h1);
				deny_addr_ff <= va;
			end
		end
	end

	// ==========================================================
	// assertions
	property p_deny_exc;
		@(posedge clk_sys) disable iff (!rstn) rsp_ff.valid && !rsp_ff.grant |-> exception_ff;
	endproperty
	a_deny_exc: assert property (p_deny_exc) else $error("deny without exception");

	property p_grant_noexc;
		@(posedge clk_sys) disable iff (!rstn) rsp_ff.grant |-> !exception_ff && rsp_ff.valid;
	endproperty
	a_grant_noexc: assert property (p_grant_noexc) else $error("grant with exception");

	property p_no_addr_on_deny;
		@(posedge clk_sys) disable iff (!rstn) exception_ff |-> rsp_ff.paddr == 24'h0;
	endproperty
	a_no_addr_on_deny: assert property (p_no_addr_on_deny) else $error("address leaked on deny");

	property p_user_rom_nowrite;
		@(posedge clk_sys) disable iff (!rstn)
			req.valid && mode_ff == MODE_USER && req.who == INIT_CPU && in_rom && req.wr |=> exception_ff;
	endproperty
	a_user_rom_nowrite: assert property (p_user_rom_nowrite) else $error("user rom write granted");

	property p_dma_rom_opt;
		@(posedge clk_sys) disable iff (!rstn)
			req.valid && req.who == INIT_DMA && req.rd && in_rom && opt_ff[`OPT_DMA_NO_ROM] |=> !rsp_ff.grant;
	endproperty
	a_dma_rom_opt: assert property (p_dma_rom_opt) else $error("dma rom read not blocked");

	property p_ee_rom_opt;
		@(posedge clk_sys) disable iff (!rstn)
			req.valid && req.rd && req.from_ee && in_rom && opt_ff[`OPT_EE_NO_ROM] |=> exception_ff;
	endproperty
	a_ee_rom_opt: assert property (p_ee_rom_opt) else $error("rom read from eeprom code");

	property p_crypto_op;
		@(posedge clk_sys) disable iff (!rstn)
			req.valid && req.who == INIT_CRYPTO && in_opram && !req.ex |=> rsp_ff.grant;
	endproperty
	a_crypto_op: assert property (p_crypto_op) else $error("crypto operand ram denied");

	property p_test_ram;
		@(posedge clk_sys) disable iff (!rstn)
			req.valid && eff_mode == MODE_TEST && req.who == INIT_CPU && in_ram && !req.ex
			&& !in_sfr |=> rsp_ff.grant;
	endproperty
	a_test_ram: assert property (p_test_ram) else $error("test mode ram denied");

	property p_mode_legal;
		@(posedge clk_sys) disable iff (!rstn)
			wr_go && aw_ff == `OFS_MODE && !mode_ok |=> mode_ff == $past(mode_ff);
	endproperty
	a_mode_legal: assert property (p_mode_legal) else $error("illegal mode");

	c_grant:  cover property (@(posedge clk_sys) disable iff (!rstn) rsp_ff.grant);
	c_deny:   cover property (@(posedge clk_sys) disable iff (!rstn) exception_ff);
	c_user:   cover property (@(posedge clk_sys) disable iff (!rstn) mode_ff == MODE_USER ##1 rsp_ff.grant);
endmodule

// ==== access_requester.sv ====
/*
 * requester model standing for the cpu core, copy engine and crypto unit.
 * assumes the checker takes a request at an edge and answers one edge later.
 */
module access_requester
	import mac_pkg::*;
(
	input  wire logic     clk_sys,
	output acc_req_t      req,
	input  wire acc_rsp_t rsp_ff,
	input  wire logic     exception_ff
);
	timeunit 1ns;
	timeprecision 1ps;

	initial req = '0;

	// ==========================================================
	// one request per call
	// once taken valid and op bits clear and address and flags invert, so a stale address can never pass for a held one
	task automatic issue(input initiator_t who, input logic [2:0] op, input logic fe, input logic fc,
		input cpu_mode_t dm, input logic [23:0] a, output logic g, output logic [23:0] pa, output logic ex);
		req <= '{1'b1, who, op[0], op[1], op[2], fe, fc, dm, a};
		@(posedge clk_sys);
		req <= '{1'b0, who, 1'b0, 1'b0, 1'b0, ~fe, ~fc, dm, ~a};
		// the answer launched at this edge is read mid-cycle, where it has settled
		@(negedge clk_sys);
		g = rsp_ff.valid ? rsp_ff.grant : 1'bx;
		pa = rsp_ff.paddr;
		ex = exception_ff;
		@(posedge clk_sys);
	endtask
endmodule

// ==== mode_based_access_checker_tb_top.sv ====
/*
 * self-checking bench for the mode based access checker: register bus tasks,
 * directed corner cases and seeded random accesses judged by a reference function.
 * assumes mac_pkg, mac_defs.svh and access_requester are compiled first.
 */
`include "mac_defs.svh"
module mode_based_access_checker_tb_top
	import mac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// wiring
	localparam logic [2:0] OP_R = 3'h1;
	localparam logic [2:0] OP_W = 3'h2;
	localparam logic [2:0] OP_X = 3'h4;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic [11:0] aw_a = '0, ar_a = '0;
	logic [31:0] w_d = '0, r_d;
	logic        aw_v = 0, w_v = 0, b_rdy = 0, ar_v = 0, r_rdy = 0, fe_v = 0, fc_v = 0;
	logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, exc;
	logic [1:0]  b_resp, r_resp;
	acc_req_t    req;
	acc_rsp_t    rsp;
	cpu_mode_t   cur = MODE_BOOT;
	int          bad_count = 0;
	int          comparisons = 0;
	int          denies = 0;
	logic [23:0] last_deny = '0;
	logic [23:0] bases [7] = '{`ROM_LO, `TROM_END, `EE_LO, `FWEE_END, `SECROW_LO, `RAM_LO, `FWRAM_END};

	always #2 clk_sys = ~clk_sys;

	mode_based_access_checker dut (.clk_sys(clk_sys), .rstn(rstn),
		.s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp),
		.s_axi_bvalid(b_v), .s_axi_bready(b_rdy), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
		.s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
		.s_axi_rready(r_rdy), .req(req), .rsp_ff(rsp), .exception_ff(exc));
	access_requester req_m (.clk_sys(clk_sys), .req(req), .rsp_ff(rsp), .exception_ff(exc));

	// ==========================================================
	// tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic ap;
		logic dp;
		ap = 1'b1;
		dp = 1'b1;
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_rdy <= 1'b1;
		while (ap || dp) begin
			@(posedge clk_sys);
			if (ap && aw_rdy) begin
				ap = 1'b0;
				aw_v <= 1'b0;
			end
			if (dp && w_rdy) begin
				dp = 1'b0;
				w_v <= 1'b0;
			end
		end
		do @(posedge clk_sys); while (b_v !== 1'b1);
		rs = b_resp;
		b_rdy <= 1'b0;
	endtask

	task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
		logic ap;
		ap = 1'b1;
		ar_a <= a;
		ar_v <= 1'b1;
		r_rdy <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (ap && ar_rdy) begin
				ap = 1'b0;
				ar_v <= 1'b0;
			end
		end while (ap || r_v !== 1'b1);
		d = r_d;
		rs = r_resp;
		r_rdy <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [1:0] rs;
		axw(a, d, rs);
	endtask

	task automatic setmode(input logic [2:0] m);
		wr(`OFS_MODE, {29'h0, m});
		cur = cpu_mode_t'(m);
	endtask

	task automatic seg(input logic [5:0] i, input logic [23:0] f, input logic [23:0] l, input logic [23:0] r,
		input logic [3:0] rt);
		wr(`OFS_SEG_BASE, {8'h0, f});
		wr(`OFS_SEG_BASE + 12'h4, {8'h0, l});
		wr(`OFS_SEG_BASE + 12'h8, {8'h0, r});
		wr(`OFS_SEG_BASE + 12'hc, {26'h0, i});
		wr(`OFS_SEG_BASE + 12'h10, {28'h0, rt});
	endtask

	task automatic acc(input initiator_t who, input logic [2:0] op, input logic [23:0] a, input logic eg,
		input logic [23:0] ep);
		logic        g;
		logic [23:0] pa;
		logic        ex;
		req_m.issue(who, op, fe_v, fc_v, cur, a, g, pa, ex);
		chk("grant", {31'h0, eg}, {31'h0, g});
		chk("paddr", {8'h0, eg ? ep : 24'h0}, {8'h0, pa});
		chk("exception", {31'h0, !eg}, {31'h0, ex});
		if (!eg) begin
			denies++;
			last_deny = a;
		end
	endtask

	// flat modes only; user mode is judged in directed cases
	function automatic logic expg(input logic [2:0] m, input logic [2:0] op, input logic [23:0] a);
		logic tr, rm, fe, ee, sc, fr, rw;
		tr = a < `TROM_END;
		rm = a < `ROM_END;
		fe = a >= `EE_LO && a < `FWEE_END;
		ee = a >= `EE_LO && a < `EE_END;
		sc = a >= `SECROW_LO && ee;
		fr = a >= `RAM_LO && a < `FWRAM_END;
		rw = a >= `RAM_LO && a < `RAM_END;
		case (m)
			3'h0: expg = (tr && !op[1]) || fe || (fr && !op[2]) || (sc && op[0]);
			3'h1: expg = (rm && !op[1]) || ee || (rw && !op[2]);
			3'h2: expg = (tr && !op[1]) || (ee && !op[2]) || (fr && !op[2]);
			3'h3: expg = (rm && !tr && !op[1]) || (ee && !fe) || (rw && !fr && !op[2]);
			default: expg = 1'b0;
		endcase
	endfunction

	task automatic report_and_stop();
		if (bad_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// sequence
	initial begin
		#100000;
		bad_count++;
		report_and_stop();
	end

	initial begin
		logic [31:0] d;
		logic [1:0]  rs;
		logic [2:0]  op;
		logic [23:0] a;
		logic        dma;
		void'($urandom(32'h22c7));
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		axr(`OFS_MODE, d, rs);
		chk("mode reset", {29'h0, `RST_MODE}, d);
		axw(`OFS_MODE, 32'h7, rs);
		axr(`OFS_MODE, d, rs);
		chk("mode kept", 32'h0, d);
		axw(12'h0f8, 32'h1, rs);
		chk("bresp unmapped", 32'h2, {30'h0, rs});
		axr(12'h0fc, d, rs);
		chk("rresp unmapped", 32'h2, {30'h0, rs});
		acc(INIT_CPU, OP_W, `SFR_LO + 24'h10, 1'b1, `SFR_LO + 24'h10);
		acc(INIT_CPU, OP_X, `SFR_LO + 24'h10, 1'b0, 24'h0);
		for (int m = 0; m < 4; m++) begin
			setmode(m[2:0]);
			repeat (40) begin
				dma = 1'($urandom);
				op = 3'h1 << ($urandom % (dma ? 2 : 3));
				a = bases[$urandom % 7] + 24'($urandom % 32'h800);
				fe_v = 1'($urandom);
				fc_v = 1'($urandom);
				acc(dma ? INIT_DMA : INIT_CPU, op, a, expg(m[2:0], op, a), a);
			end
		end
		fc_v = 1'b0;
		setmode(3'h1);
		wr(`OFS_OPTIONS, 32'h1);
		fe_v = 1'b1;
		acc(INIT_CPU, OP_R, `TROM_END, 1'b0, 24'h0);
		fe_v = 1'b0;
		acc(INIT_CPU, OP_R, `TROM_END, 1'b1, `TROM_END);
		wr(`OFS_OPTIONS, 32'h2);
		acc(INIT_DMA, OP_R, 24'h10, 1'b0, 24'h0);
		acc(INIT_DMA, OP_R, `EE_LO, 1'b1, `EE_LO);
		wr(`OFS_OPTIONS, 32'h4);
		acc(INIT_DMA, OP_R, `EE_LO, 1'b0, 24'h0);
		acc(INIT_DMA, OP_R, 24'h10, 1'b1, 24'h10);
		wr(`OFS_OPTIONS, 32'h0);
		acc(INIT_CRYPTO, OP_W, `OPRAM_LO + 24'h20, 1'b1, `OPRAM_LO + 24'h20);
		acc(INIT_CRYPTO, OP_R, `OPRAM_LO + 24'h20, 1'b1, `OPRAM_LO + 24'h20);
		setmode(3'h2);
		acc(INIT_CPU, OP_X, `EE_LO, 1'b0, 24'h0);
		wr(`OFS_FW_CTRL_HIGH, 32'h8000);
		acc(INIT_CPU, OP_X, `EE_LO, 1'b1, `EE_LO);
		acc(INIT_CPU, OP_R, `SFR_HWC_LO + 24'h1400, 1'b0, 24'h0);
		wr(`OFS_FW_CTRL_LOW, 32'h20);
		acc(INIT_CPU, OP_R, `SFR_HWC_LO + 24'h1400, 1'b1, `SFR_HWC_LO + 24'h1400);
		acc(INIT_CPU, OP_W, 24'h200840, 1'b0, 24'h0);
		wr(`OFS_XW_BASE_LOW, 32'h800);
		wr(`OFS_XW_BASE_HIGH, 32'h20);
		wr(`OFS_XW_SIZE_LOW, 32'h100);
		acc(INIT_CPU, OP_W, 24'h200840, 1'b1, 24'h200840);
		acc(INIT_CPU, OP_W, 24'h201800, 1'b0, 24'h0);
		seg(6'd0, 24'h4000, 24'h4fff, 24'h0, 4'h0);
		seg(6'd63, 24'h4000, 24'h4fff, 24'h100, 4'h5);
		seg(6'd1, 24'h201000, 24'h2010ff, 24'h0, 4'h7);
		setmode(3'h4);
		acc(INIT_CPU, OP_R, 24'h4010, 1'b1, 24'h4110);
		acc(INIT_CPU, OP_W, 24'h4010, 1'b0, 24'h0);
		acc(INIT_CPU, OP_R, 24'h5000, 1'b0, 24'h0);
		acc(INIT_CPU, OP_W, 24'h201010, 1'b1, 24'h201010);
		acc(INIT_CPU, OP_X, 24'h201010, 1'b0, 24'h0);
		axr(`OFS_STATUS, d, rs);
		chk("deny count", {16'h0, denies[15:0]}, {16'h0, d[15:0]});
		axr(`OFS_DENY_ADDR, d, rs);
		chk("deny addr", {8'h0, last_deny}, {8'h0, d[23:0]});
		report_and_stop();
	end
endmodule
